/* File: inc/spr_bank_pkg.sv */
// Purpose: Shared constants for the special register bank
// Assumes: 32-bit registers, word-indexed bus map
// Notes:   Byte address of a register is its index times four
package spr_bank_pkg;
  localparam int SPR_W    = 32;
  localparam int IDX_W    = 6;
  localparam int SCR_N    = 4;
  localparam int BAT_N    = 16;
  localparam int BAT_IW   = 4;
  localparam int ADDR_LSB = 2;

  // Register indices
  localparam logic [IDX_W-1:0] IDX_INT_EXC  = 6'h00;
  localparam logic [IDX_W-1:0] IDX_LINK     = 6'h01;
  localparam logic [IDX_W-1:0] IDX_COUNT    = 6'h02;
  localparam logic [IDX_W-1:0] IDX_F_CAUSE  = 6'h03;
  localparam logic [IDX_W-1:0] IDX_F_ADDR   = 6'h04;
  localparam logic [IDX_W-1:0] IDX_TIMER    = 6'h05;
  localparam logic [IDX_W-1:0] IDX_PG_BASE  = 6'h06;
  localparam logic [IDX_W-1:0] IDX_EXT_CTL  = 6'h07;
  localparam logic [IDX_W-1:0] IDX_SAVE_PC  = 6'h0C;
  localparam logic [IDX_W-1:0] IDX_SAVE_MSR = 6'h0D;
  localparam logic [IDX_W-1:0] IDX_TIME_LO  = 6'h0E;
  localparam logic [IDX_W-1:0] IDX_TIME_HI  = 6'h0F;
  localparam logic [IDX_W-1:0] IDX_VERSION  = 6'h10;
  localparam logic [IDX_W-1:0] IDX_IMPL     = 6'h11;
  localparam logic [IDX_W-1:0] IDX_BRK      = 6'h12;
  localparam logic [IDX_W-1:0] IDX_D_MISS   = 6'h13;
  localparam logic [IDX_W-1:0] IDX_I_MISS   = 6'h14;
  localparam logic [IDX_W-1:0] IDX_HASH_P   = 6'h15;
  localparam logic [IDX_W-1:0] IDX_HASH_S   = 6'h16;
  localparam logic [IDX_W-1:0] IDX_I_CMP    = 6'h17;
  localparam logic [IDX_W-1:0] IDX_D_CMP    = 6'h18;
  localparam logic [IDX_W-1:0] IDX_PHYS     = 6'h19;
  // Scratch at 0x08..0x0B, translation pairs at 0x20..0x2F
  localparam logic [3:0]       SCR_SEL      = 4'h2;
  localparam logic [1:0]       BAT_SEL      = 2'h2;

  // Field positions
  localparam int MSR_USER_BIT = 14;
  localparam int IE_SO_BIT    = 31;
  localparam int IE_OV_BIT    = 30;
  localparam int IE_CA_BIT    = 29;
  localparam int IE_BC_W      = 7;
  localparam int EXT_EN_BIT   = 31;
  localparam int BRK_EN_BIT   = 1;
  localparam int BRK_CMP_LSB  = 2;
  localparam int TMR_SIGN_BIT = 31;

  // Values
  localparam logic [SPR_W-1:0]   WORD_ZERO = 32'h0;
  localparam logic [SPR_W-1:0]   CNT_STEP  = 32'h1;
  localparam logic [2*SPR_W-1:0] TIME_STEP = 64'h1;
  localparam logic [1:0]         HTRANS_IDLE = 2'h0;
  localparam int                 HTRANS_ACT  = 1;
  localparam logic               HRESP_OKAY  = 1'h0;
endpackage

/* File: inc/timer_if.sv */
// Purpose: Carrier between register bank and its timer unit
// Assumes: Single core clock
// Notes:   Write strobes are one-cycle pulses
`timescale 1ns/1ps
interface timer_if;
  import spr_bank_pkg::*;
  logic                 lo_we;
  logic                 hi_we;
  logic                 cnt_we;
  logic [SPR_W-1:0]     wdata;
  logic [2*SPR_W-1:0]   time_q;
  logic [SPR_W-1:0]     cnt_q;
  logic                 expired;
  modport ctl (output lo_we, hi_we, cnt_we, wdata,
               input  time_q, cnt_q, expired);
  modport tmr (input  lo_we, hi_we, cnt_we, wdata,
               output time_q, cnt_q, expired);
endinterface

/* File: rtl/countdown_timer.sv */
// Purpose: Time-of-day counter and countdown timer
// Assumes: Both advance on every core clock
// Notes:   Expiry is the sign bit going from clear to set
`timescale 1ns/1ps
module countdown_timer
  import spr_bank_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // Bank side
  timer_if.tmr     tif
);

  typedef struct packed {
    logic [2*SPR_W-1:0] time_q;
    logic [SPR_W-1:0]   cnt;
    logic               expired;
  } tmr_state_t;

  tmr_state_t s_r;
  tmr_state_t s_nxt;

  always_comb
  begin
    s_nxt = s_r;
    s_nxt.time_q = s_r.time_q + TIME_STEP;
    if (tif.lo_we)
      s_nxt.time_q[SPR_W-1:0] = tif.wdata;
    if (tif.hi_we)
      s_nxt.time_q[2*SPR_W-1:SPR_W] = tif.wdata;
    s_nxt.cnt = s_r.cnt - CNT_STEP;
    if (tif.cnt_we)
      s_nxt.cnt = tif.wdata;
    // A fresh software load never fires by itself
    s_nxt.expired = !tif.cnt_we && !s_r.cnt[TMR_SIGN_BIT]
                    && s_nxt.cnt[TMR_SIGN_BIT];
  end

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  assign tif.time_q  = s_r.time_q;
  assign tif.cnt_q   = s_r.cnt;
  assign tif.expired = s_r.expired;

endmodule // countdown_timer

/* File: rtl/spr_bank.sv */
// Purpose: Special register bank of the core, on an AHB-Lite slave
// Assumes: Core-side strobes come from logic on the same clock
// Notes:   Zero-wait slave; read data registered at address phase
`timescale 1ns/1ps

// Functional notes
// - Privilege of each access comes from the user bit of machine state.
// - Registers are read and written explicitly and updated by side effect.
// - Every register in the bank is 32 bits wide.
// - Link reg feeds branch targets; branch-and-link loads return address.
// - Branch-and-count decrements loop count, then tests it for the branch.
// - Integer exception reg: summary overflow, carry, overflow, byte count.
// - Supervisor only: fault, timer, save, translation and impl registers.
// - Fault cause register records why a data or alignment fault occurred.
// - Fault address register holds the faulting access address.
// - Countdown timer decrements always and raises an exception on expiry.
// - Save return address taken on exception, supplied on return.
// - Save machine status taken on exception, restored on return.
// - Four scratch registers for the operating system, no side effects.
// - External access control reg gates external control in/out words.
// - 64-bit time-of-day counter read as separate upper and lower halves.
// - Version register is read-only, reports model and revision.
// - Sixteen block translation registers, four data and four insn pairs.
// - Miss address registers are read-only, loaded by hardware on misses.
// - On a miss, group pointers show primary and secondary group addresses.
// - Compare registers hold first word of the sought table entry.
// - Table search loads physical address register with the entry word two.
// - Breakpoint address matched in dispatch raises a breakpoint exception.
module spr_bank
  import spr_bank_pkg::*;
#(
  parameter logic [SPR_W-1:0] VERSION_ID = 32'h0000_0001 // Arbitrary value
)
(
  // Clock and reset
  input  wire logic             clock,
  input  wire logic             rst_b,
  // AHB-Lite slave
  input  wire logic             hsel,
  input  wire logic [31:0]      haddr,
  input  wire logic [1:0]       htrans,
  input  wire logic             hwrite,
  input  wire logic [2:0]       hsize,
  input  wire logic [31:0]      hwdata,
  input  wire logic             hready,
  output logic                  hreadyout,
  output logic                  hresp,
  output logic [31:0]           hrdata,
  // Machine state
  input  wire logic [SPR_W-1:0] machine_state_reg,
  // Branch unit
  input  wire logic             link_load,
  input  wire logic [SPR_W-1:0] link_ret_addr,
  output logic [SPR_W-1:0]      branch_link_reg,
  input  wire logic             count_dec,
  output logic [SPR_W-1:0]      loop_count_reg,
  output logic                  count_branch_ok,
  // Integer unit
  input  wire logic             ie_update,
  input  wire logic             ie_ca_in,
  input  wire logic             ie_ov_in,
  output logic [SPR_W-1:0]      integer_exception_reg,
  // Data faults
  input  wire logic             fault_capture,
  input  wire logic [SPR_W-1:0] fault_cause_in,
  input  wire logic [SPR_W-1:0] fault_addr_in,
  // Exception entry and return
  input  wire logic             exc_take,
  input  wire logic [SPR_W-1:0] exc_pc,
  input  wire logic [SPR_W-1:0] exc_msr,
  output logic [SPR_W-1:0]      resume_addr,
  output logic [SPR_W-1:0]      restore_msr,
  output logic                  timer_exc,
  output logic                  ext_access_ok,
  output logic                  priv_violation,
  // Translation miss
  input  wire logic             dtlb_miss,
  input  wire logic             itlb_miss,
  input  wire logic [SPR_W-1:0] miss_addr,
  input  wire logic [SPR_W-1:0] miss_hash_p,
  input  wire logic [SPR_W-1:0] miss_hash_s,
  input  wire logic [SPR_W-1:0] miss_cmp,
  input  wire logic             phys_load,
  input  wire logic [SPR_W-1:0] phys_word,
  // Dispatch breakpoint
  input  wire logic             dispatch_valid,
  input  wire logic [SPR_W-1:0] dispatch_addr,
  output logic                  insn_break
);

  typedef struct packed {
    // Software-visible words
    logic [SPR_W-1:0] int_exc;
    logic [SPR_W-1:0] link;
    logic [SPR_W-1:0] count;
    logic [SPR_W-1:0] f_cause;
    logic [SPR_W-1:0] f_addr;
    logic [SPR_W-1:0] pg_base;
    logic [SPR_W-1:0] ext_ctl;
    logic [SPR_W-1:0] save_pc;
    logic [SPR_W-1:0] save_msr;
    logic [SPR_W-1:0] impl;
    logic [SPR_W-1:0] brk;
    logic [SPR_W-1:0] d_miss;
    logic [SPR_W-1:0] i_miss;
    logic [SPR_W-1:0] hash_p;
    logic [SPR_W-1:0] hash_s;
    logic [SPR_W-1:0] i_cmp;
    logic [SPR_W-1:0] d_cmp;
    logic [SPR_W-1:0] phys;
    logic [SCR_N-1:0][SPR_W-1:0] scratch;
    logic [BAT_N-1:0][SPR_W-1:0] block_translation_regs;
    // Address phase, held over into the data phase
    logic             ph_wr;
    logic             ph_deny;
    logic [IDX_W-1:0] ph_idx;
    // Registered answers and one-cycle pulses
    logic [SPR_W-1:0] rdata;
    logic             count_ok;
    logic             brk_hit;
    logic             priv_hit;
  } bank_state_t;

  bank_state_t      s_r;
  bank_state_t      s_nxt;

  timer_if          tif();

  logic             addr_ph;
  logic [IDX_W-1:0] a_idx;
  logic             hi_zero;
  logic             mapped;
  logic             user_mode_bit;
  logic             sup_only;
  logic             priv_hit;
  logic             deny;
  logic             wr_ok;
  logic             ph_ro;
  logic [SPR_W-1:0] rd_val;
  logic [SPR_W-1:0] count_less;

  countdown_timer u_timer
  (
    .clock (clock),
    .rst_b (rst_b),
    .tif   (tif.tmr)
  );

  // Address phase decode
  // Transfer size is not decoded: every register is one whole word
  assign addr_ph = hsel && hready && htrans[HTRANS_ACT];
  assign a_idx   = haddr[ADDR_LSB +: IDX_W];
  assign hi_zero = (haddr[31:ADDR_LSB+IDX_W] == '0);
  // Unmapped words read zero and drop writes, yet still answer OKAY
  assign mapped  = hi_zero && ((a_idx <= IDX_PHYS)
                   || (a_idx[IDX_W-1 -: 2] == BAT_SEL));
  // Privilege goes with the address phase, not with the data phase
  assign user_mode_bit = machine_state_reg[MSR_USER_BIT];
  // Only the three user-level registers sit below the fault cause
  assign sup_only = (a_idx >= IDX_F_CAUSE);
  // A privilege denial is silent on the bus; the core learns of it by a pulse
  assign priv_hit = addr_ph && mapped && user_mode_bit && sup_only;
  assign deny     = !mapped || priv_hit;
  assign wr_ok    = s_r.ph_wr && !s_r.ph_deny;
  // Read-only words ignore the bus; hardware loads the miss words, version is fixed
  assign ph_ro    = (s_r.ph_idx == IDX_VERSION)
                    || (s_r.ph_idx == IDX_D_MISS)
                    || (s_r.ph_idx == IDX_I_MISS);
  // One subtractor serves both the new count and its branch test
  assign count_less = s_r.count - CNT_STEP;

  // Timer writes land in the data phase like every other write
  assign tif.wdata  = hwdata;
  assign tif.lo_we  = wr_ok && (s_r.ph_idx == IDX_TIME_LO);
  assign tif.hi_we  = wr_ok && (s_r.ph_idx == IDX_TIME_HI);
  assign tif.cnt_we = wr_ok && (s_r.ph_idx == IDX_TIMER);

  // Read mux on the address phase index
  always_comb
  begin
    rd_val = WORD_ZERO;
    case (a_idx)
      IDX_INT_EXC:  rd_val = s_r.int_exc;
      IDX_LINK:     rd_val = s_r.link;
      IDX_COUNT:    rd_val = s_r.count;
      IDX_F_CAUSE:  rd_val = s_r.f_cause;
      IDX_F_ADDR:   rd_val = s_r.f_addr;
      IDX_TIMER:    rd_val = tif.cnt_q;
      IDX_PG_BASE:  rd_val = s_r.pg_base;
      IDX_EXT_CTL:  rd_val = s_r.ext_ctl;
      IDX_SAVE_PC:  rd_val = s_r.save_pc;
      IDX_SAVE_MSR: rd_val = s_r.save_msr;
      IDX_TIME_LO:  rd_val = tif.time_q[SPR_W-1:0];
      IDX_TIME_HI:  rd_val = tif.time_q[2*SPR_W-1:SPR_W];
      IDX_VERSION:  rd_val = VERSION_ID;
      IDX_IMPL:     rd_val = s_r.impl;
      IDX_BRK:      rd_val = s_r.brk;
      IDX_D_MISS:   rd_val = s_r.d_miss;
      IDX_I_MISS:   rd_val = s_r.i_miss;
      IDX_HASH_P:   rd_val = s_r.hash_p;
      IDX_HASH_S:   rd_val = s_r.hash_s;
      IDX_I_CMP:    rd_val = s_r.i_cmp;
      IDX_D_CMP:    rd_val = s_r.d_cmp;
      IDX_PHYS:     rd_val = s_r.phys;
      default:
      begin
        if (a_idx[IDX_W-1 -: 2] == BAT_SEL)
          rd_val = s_r.block_translation_regs[a_idx[BAT_IW-1:0]];
        else if (a_idx[IDX_W-1:2] == SCR_SEL)
          rd_val = s_r.scratch[a_idx[1:0]];
        else
          rd_val = WORD_ZERO;
      end
    endcase
    // A write still in its data phase is forwarded to a following read
    if (wr_ok && !ph_ro && (s_r.ph_idx == a_idx))
      rd_val = hwdata;
  end

  always_comb
  begin
    s_nxt          = s_r;
    s_nxt.brk_hit  = 1'b0;
    s_nxt.priv_hit = 1'b0;

    // Data phase: explicit write
    if (wr_ok)
    begin
      case (s_r.ph_idx)
        IDX_INT_EXC:  s_nxt.int_exc  = hwdata;
        IDX_LINK:     s_nxt.link     = hwdata;
        IDX_COUNT:    s_nxt.count    = hwdata;
        IDX_F_CAUSE:  s_nxt.f_cause  = hwdata;
        IDX_F_ADDR:   s_nxt.f_addr   = hwdata;
        IDX_PG_BASE:  s_nxt.pg_base  = hwdata;
        IDX_EXT_CTL:  s_nxt.ext_ctl  = hwdata;
        IDX_SAVE_PC:  s_nxt.save_pc  = hwdata;
        IDX_SAVE_MSR: s_nxt.save_msr = hwdata;
        IDX_IMPL:     s_nxt.impl     = hwdata;
        IDX_BRK:      s_nxt.brk      = hwdata;
        IDX_HASH_P:   s_nxt.hash_p   = hwdata;
        IDX_HASH_S:   s_nxt.hash_s   = hwdata;
        IDX_I_CMP:    s_nxt.i_cmp    = hwdata;
        IDX_D_CMP:    s_nxt.d_cmp    = hwdata;
        IDX_PHYS:     s_nxt.phys     = hwdata;
        default:
        begin
          // Version and miss registers fall here and stay unchanged
          if (s_r.ph_idx[IDX_W-1 -: 2] == BAT_SEL)
            s_nxt.block_translation_regs[s_r.ph_idx[BAT_IW-1:0]] = hwdata;
          else if (s_r.ph_idx[IDX_W-1:2] == SCR_SEL)
            s_nxt.scratch[s_r.ph_idx[1:0]] = hwdata;
        end
      endcase
    end

    // Address phase: capture control and read data
    s_nxt.ph_wr = 1'b0;
    if (addr_ph)
    begin
      s_nxt.ph_wr    = hwrite;
      s_nxt.ph_idx   = a_idx;
      s_nxt.ph_deny  = deny;
      s_nxt.priv_hit = priv_hit;
      if (!hwrite)
        s_nxt.rdata = deny ? WORD_ZERO : rd_val;
    end

    // Implicit updates come last, so the hardware wins a tie
    if (link_load)
      s_nxt.link = link_ret_addr;
    if (count_dec)
    begin
      s_nxt.count    = count_less;
      s_nxt.count_ok = (count_less != WORD_ZERO);
    end
    if (ie_update)
    begin
      s_nxt.int_exc[IE_CA_BIT] = ie_ca_in;
      s_nxt.int_exc[IE_OV_BIT] = ie_ov_in;
      // Summary overflow is sticky until software clears it
      s_nxt.int_exc[IE_SO_BIT] = s_r.int_exc[IE_SO_BIT] || ie_ov_in;
    end
    if (fault_capture)
    begin
      s_nxt.f_cause = fault_cause_in;
      s_nxt.f_addr  = fault_addr_in;
    end
    if (exc_take)
    begin
      s_nxt.save_pc  = exc_pc;
      s_nxt.save_msr = exc_msr;
    end
    if (dtlb_miss)
    begin
      s_nxt.d_miss = miss_addr;
      s_nxt.d_cmp  = miss_cmp;
    end
    if (itlb_miss)
    begin
      s_nxt.i_miss = miss_addr;
      s_nxt.i_cmp  = miss_cmp;
    end
    if (dtlb_miss || itlb_miss)
    begin
      s_nxt.hash_p = miss_hash_p;
      s_nxt.hash_s = miss_hash_s;
    end
    if (phys_load)
      s_nxt.phys = phys_word;

    // Word-aligned compare; low bits of the register hold the enable
    s_nxt.brk_hit = dispatch_valid && s_r.brk[BRK_EN_BIT]
                    && (s_r.brk[SPR_W-1:BRK_CMP_LSB]
                        == dispatch_addr[SPR_W-1:BRK_CMP_LSB]);
  end

  // Reset clears every word, so hrdata reads zero until the first read
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  // Bus answer: always ready, always OKAY
  assign hreadyout = 1'b1;
  assign hresp     = HRESP_OKAY;
  assign hrdata    = s_r.rdata;

  // Core-facing views
  assign branch_link_reg       = s_r.link;
  assign loop_count_reg        = s_r.count;
  assign count_branch_ok       = s_r.count_ok;
  assign integer_exception_reg = s_r.int_exc;
  assign resume_addr           = s_r.save_pc;
  assign restore_msr           = s_r.save_msr;
  assign ext_access_ok         = s_r.ext_ctl[EXT_EN_BIT];
  assign timer_exc             = tif.expired;
  assign priv_violation        = s_r.priv_hit;
  assign insn_break            = s_r.brk_hit;

endmodule // spr_bank

/* File: sim/spr_bank_properties.sv */
// Purpose: Concurrent checks on the special register bank ports
// Assumes: Single core clock, asynchronous active-low reset
// Notes:   Privilege is judged on the address phase, as the slave does
`timescale 1ns/1ps
module spr_bank_properties
  import spr_bank_pkg::*;
(
  // Clock and reset
  input logic             clock,
  input logic             rst_b,
  // Bus
  input logic             hsel,
  input logic [31:0]      haddr,
  input logic [1:0]       htrans,
  input logic             hready,
  input logic             hreadyout,
  input logic             hresp,
  input logic [SPR_W-1:0] machine_state_reg,
  input logic             priv_violation,
  // Core side
  input logic             link_load,
  input logic [SPR_W-1:0] link_ret_addr,
  input logic [SPR_W-1:0] branch_link_reg,
  input logic             count_dec,
  input logic [SPR_W-1:0] loop_count_reg,
  input logic             count_branch_ok,
  input logic             ie_update,
  input logic             ie_ca_in,
  input logic             ie_ov_in,
  input logic [SPR_W-1:0] integer_exception_reg,
  input logic             exc_take,
  input logic [SPR_W-1:0] exc_pc,
  input logic [SPR_W-1:0] exc_msr,
  input logic [SPR_W-1:0] resume_addr,
  input logic [SPR_W-1:0] restore_msr,
  input logic             timer_exc
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);

  // Only indices 0..2 are open to user code
  logic user_acc;
  assign user_acc = hsel && hready && htrans[HTRANS_ACT]
                    && machine_state_reg[MSR_USER_BIT]
                    && haddr[31:8] == 24'h0 && haddr[7:2] >= 6'h03
                    && (haddr[7:2] <= IDX_PHYS || haddr[7:6] == BAT_SEL);

  sequence deny_seq;
    user_acc ##1 priv_violation;
  endsequence

  sequence dec_seq;
    count_dec ##1 loop_count_reg == $past(loop_count_reg) - CNT_STEP;
  endsequence

  bus_okay_a: assert property (hreadyout && hresp == HRESP_OKAY)
    else $error("bus slave not ready or not okay");
  deny_pulse_a: assert property (user_acc |-> deny_seq)
    else $error("denied access gave no violation pulse");
  pulse_cause_a: assert property (priv_violation |-> $past(user_acc))
    else $error("violation pulse without a user access");
  link_load_a: assert property (link_load |=>
    branch_link_reg == $past(link_ret_addr))
    else $error("link register not loaded");
  count_dec_a: assert property (count_dec |-> dec_seq
    ##0 count_branch_ok == (loop_count_reg != WORD_ZERO))
    else $error("loop count step or branch test wrong");
  ie_bits_a: assert property (ie_update |=>
    integer_exception_reg[31:29] == {$past(integer_exception_reg[31])
    | $past(ie_ov_in), $past(ie_ov_in), $past(ie_ca_in)})
    else $error("integer exception bits wrong");
  save_pc_a: assert property (exc_take |=>
    resume_addr == $past(exc_pc))
    else $error("resume address not captured");
  save_msr_a: assert property (exc_take |=>
    restore_msr == $past(exc_msr))
    else $error("machine status not captured");
  timer_once_a: assert property (timer_exc |=> !timer_exc [*8])
    else $error("timer exception longer than one cycle");
endmodule // spr_bank_properties

bind spr_bank spr_bank_properties u_props (
  .clock(clock), .rst_b(rst_b), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hready(hready), .hreadyout(hreadyout),
  .hresp(hresp), .machine_state_reg(machine_state_reg),
  .priv_violation(priv_violation), .link_load(link_load),
  .link_ret_addr(link_ret_addr), .branch_link_reg(branch_link_reg),
  .count_dec(count_dec), .loop_count_reg(loop_count_reg),
  .count_branch_ok(count_branch_ok), .ie_update(ie_update),
  .ie_ca_in(ie_ca_in), .ie_ov_in(ie_ov_in),
  .integer_exception_reg(integer_exception_reg), .exc_take(exc_take),
  .exc_pc(exc_pc), .exc_msr(exc_msr), .resume_addr(resume_addr),
  .restore_msr(restore_msr), .timer_exc(timer_exc));

/* File: sim/tb_top.sv */
// Purpose: Self-checking bench for the special register bank
// Assumes: Zero-wait bus slave; core strobes taken on any high edge
// Notes:   Table rows first, then side effects, privilege, timers, reset
`timescale 1ns/1ps
module tb_top;
  import spr_bank_pkg::*;
  typedef struct {logic [5:0] i; logic [31:0] w; logic [31:0] e;} row_t;
  localparam logic [31:0] VER = 32'h0000_0005; // Arbitrary value
  logic        clock, rst_b, hsel, hwrite, hreadyout, hresp, pv;
  logic        link_load, count_dec, count_branch_ok, ie_update, ie_ca_in;
  logic        ie_ov_in, fault_capture, exc_take, timer_exc, ext_access_ok;
  logic        priv_violation, dtlb_miss, itlb_miss, phys_load, insn_break;
  logic        dispatch_valid;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata, machine_state_reg, link_ret_addr;
  logic [31:0] branch_link_reg, loop_count_reg, integer_exception_reg;
  logic [31:0] fault_cause_in, fault_addr_in, exc_pc, exc_msr, resume_addr;
  logic [31:0] restore_msr, miss_addr, miss_hash_p, miss_hash_s, miss_cmp;
  logic [31:0] phys_word, dispatch_addr, r0, r1;
  int          fail_count, comparisons, n;
  row_t        rows [17] = '{
    '{6'h00, 32'h7F, 32'h7F}, '{6'h01, 32'hAAAA5554, 32'hAAAA5554},
    '{6'h02, 32'h1, 32'h1}, '{6'h03, 32'hC0000000, 32'hC0000000},
    '{6'h06, 32'h12340000, 32'h12340000}, '{6'h07, 32'h80000000,
    32'h80000000}, '{6'h08, 32'h8, 32'h8}, '{6'h09, 32'h9, 32'h9},
    '{6'h0A, 32'hA, 32'hA}, '{6'h0B, 32'hB, 32'hB},
    '{6'h10, 32'hFFFFFFFF, VER}, '{6'h11, 32'h3, 32'h3},
    '{6'h13, 32'h5A5A5A5A, 32'h0}, '{6'h14, 32'h5A5A5A5A, 32'h0},
    '{6'h1A, 32'h5, 32'h0}, '{6'h20, 32'h11110000, 32'h11110000},
    '{6'h2F, 32'h2222FFFF, 32'h2222FFFF}};

  spr_bank #(.VERSION_ID(VER)) uut (.clock, .rst_b, .hsel, .haddr,
    .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout), .hreadyout,
    .hresp, .hrdata, .machine_state_reg, .link_load, .link_ret_addr,
    .branch_link_reg, .count_dec, .loop_count_reg, .count_branch_ok,
    .ie_update, .ie_ca_in, .ie_ov_in, .integer_exception_reg,
    .fault_capture, .fault_cause_in, .fault_addr_in, .exc_take, .exc_pc,
    .exc_msr, .resume_addr, .restore_msr, .timer_exc, .ext_access_ok,
    .priv_violation, .dtlb_miss, .itlb_miss, .miss_addr, .miss_hash_p,
    .miss_hash_s, .miss_cmp, .phys_load, .phys_word, .dispatch_valid,
    .dispatch_addr, .insn_break);

  task automatic chk(input string s, input logic [31:0] e,
                     input logic [31:0] g);
    comparisons++;
    if (g !== e)
    begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", s, e, g);
    end
  endtask

  // Master waits on hready; the slave sets the pace, not the bench
  task automatic bus(input logic w, input logic [5:0] i,
                     input logic [31:0] d, output logic [31:0] r);
    haddr  <= 32'(i) << ADDR_LSB;
    hwrite <= w;
    htrans <= 2'h2;
    @(posedge clock);
    while (hreadyout !== 1'b1) @(posedge clock);
    htrans <= HTRANS_IDLE;
    hwdata <= d;
    @(posedge clock);
    while (hreadyout !== 1'b1) @(posedge clock);
    r  = hrdata;
    pv = priv_violation;
  endtask

  task automatic wr(input logic [5:0] i, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, i, d, r);
  endtask

  task automatic rdc(input string s, input logic [5:0] i,
                     input logic [31:0] e);
    logic [31:0] r;
    bus(1'b0, i, 32'h0, r);
    chk(s, e, r);
  endtask

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  initial
  begin
    repeat (3000) @(posedge clock);
    fail_count++;
    $display("unexpected watchdog expected done seen hang");
    tally_and_finish();
  end

  initial
  begin
    {rst_b, hwrite, link_load, count_dec, ie_update, ie_ca_in, ie_ov_in,
     fault_capture, exc_take, dtlb_miss, itlb_miss, phys_load,
     dispatch_valid} = '0;
    {haddr, hwdata, machine_state_reg, link_ret_addr, fault_cause_in,
     fault_addr_in, exc_pc, exc_msr, miss_addr, miss_hash_p, miss_hash_s,
     miss_cmp, phys_word, dispatch_addr} = '0;
    hsel   = 1'b1;
    htrans = HTRANS_IDLE;
    hsize  = 3'h2;
    repeat (6) @(posedge clock);
    rst_b <= 1'b1;
    foreach (rows[k]) wr(rows[k].i, rows[k].w);
    foreach (rows[k])
      rdc("table", rows[k].i, rows[k].e);
    chk("ext ok", 32'h1, {31'h0, ext_access_ok});
    // All independent side effects land on one edge
    {link_ret_addr, fault_cause_in, fault_addr_in, exc_pc, exc_msr} <=
      {32'h4444, 32'h02000000, 32'hABC, 32'h700, 32'h9032};
    {miss_addr, miss_hash_p, miss_hash_s, miss_cmp, phys_word} <=
      {32'hD000, 32'h100, 32'h200, 32'h80000001, 32'hF012};
    {link_load, fault_capture, exc_take, ie_update, ie_ca_in, ie_ov_in,
     dtlb_miss, phys_load} <= '1;
    @(posedge clock);
    {link_load, fault_capture, exc_take, ie_update, dtlb_miss,
     phys_load} <= '0;
    {miss_addr, miss_hash_p, miss_hash_s, miss_cmp} <=
      {32'hE000, 32'h300, 32'h400, 32'h80000002};
    itlb_miss <= 1'b1;
    @(posedge clock);
    itlb_miss <= 1'b0;
    @(posedge clock);
    chk("link", 32'h4444, branch_link_reg);
    chk("resume", 32'h700, resume_addr);
    chk("restore", 32'h9032, restore_msr);
    rdc("int exc", IDX_INT_EXC, 32'hE000007F);
    rdc("cause", IDX_F_CAUSE, 32'h02000000);
    rdc("fault addr", IDX_F_ADDR, 32'hABC);
    rdc("save pc", IDX_SAVE_PC, 32'h700);
    rdc("save msr", IDX_SAVE_MSR, 32'h9032);
    rdc("d miss", IDX_D_MISS, 32'hD000);
    rdc("i miss", IDX_I_MISS, 32'hE000);
    rdc("hash p", IDX_HASH_P, 32'h300);
    rdc("hash s", IDX_HASH_S, 32'h400);
    rdc("d cmp", IDX_D_CMP, 32'h80000001);
    rdc("i cmp", IDX_I_CMP, 32'h80000002);
    rdc("phys", IDX_PHYS, 32'hF012);
    for (int k = 0; k < 2; k++)
    begin
      count_dec <= 1'b1;
      @(posedge clock);
      count_dec <= 1'b0;
      @(posedge clock);
      chk("count", k ? 32'hFFFFFFFF : 32'h0, loop_count_reg);
      chk("count ok", {31'h0, k[0]}, {31'h0, count_branch_ok});
    end
    machine_state_reg <= 32'h1 << MSR_USER_BIT;
    wr(IDX_F_CAUSE, 32'h1);
    chk("deny pulse", 32'h1, {31'h0, pv});
    rdc("user link", IDX_LINK, 32'h4444);
    chk("no pulse", 32'h0, {31'h0, pv});
    rdc("user time", IDX_TIME_LO, 32'h0);
    machine_state_reg <= 32'h0;
    rdc("kept", IDX_F_CAUSE, 32'h02000000);
    wr(IDX_TIME_HI, 32'hA5);
    wr(IDX_TIME_LO, 32'h0);
    bus(1'b0, IDX_TIME_LO, 32'h0, r0);
    bus(1'b0, IDX_TIME_LO, 32'h0, r1);
    chk("time step", 32'h2, r1 - r0);
    rdc("time hi", IDX_TIME_HI, 32'hA5);
    // A short countdown must expire well before the wait runs out
    wr(IDX_TIMER, 32'h3);
    n = 0;
    while (timer_exc !== 1'b1 && n < 20)
    begin
      @(posedge clock);
      n++;
    end
    chk("timer exc", 32'h1, {31'h0, timer_exc});
    wr(IDX_BRK, 32'h1002);
    for (int k = 0; k < 2; k++)
    begin
      dispatch_addr  <= k ? 32'h2000 : 32'h1000;
      dispatch_valid <= 1'b1;
      @(posedge clock);
      dispatch_valid <= 1'b0;
      @(posedge clock);
      chk("break", {31'h0, !k[0]}, {31'h0, insn_break});
    end
    rst_b <= 1'b0;
    @(posedge clock);
    chk("rst link", 32'h0, branch_link_reg);
    chk("rst ready", 32'h1, {31'h0, hreadyout});
    chk("rst ext", 32'h0, {31'h0, ext_access_ok});
    rst_b <= 1'b1;
    rdc("rst scratch", 6'h08, 32'h0);
    tally_and_finish();
  end
endmodule // tb_top
